// ===== hdl/i2c_slave_transmit.sv
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ns
`include "i2c_slave_tx_defs.svh"
// Summary of operation
// (RULE1) Matching read address: set direction, load address into buffer, acknowledge ninth bit.
// (RULE2) After address acknowledge, clear clock_release and hold the clock line low.
// (RULE3) Master generates no clock pulse while the slave holds the clock low.
// (RULE4) Firmware write to the data buffer also loads the transmit shift register.
// (RULE5) Setting clock_release frees the clock line so the byte can be clocked out.
// (RULE6) Eight data bits shift out, each changed on a falling clock edge; the code drives the first bit when clock_release frees the clock line.
// (RULE7) Master acknowledge latched on ninth rising edge into master_ack_status.
// (RULE8) A not-acknowledge ends the transfer; device idles until a new start.
// (RULE9) Master acknowledge stretches the clock again; firmware reloads buffer and releases.
// (RULE10) On not-acknowledge the clock is not held, but the interrupt flag still rises.
// (RULE11) Interrupt flag set for each byte on the ninth falling edge; firmware clears it.
// (RULE12) Collision while shifting, if enabled, sets bus_collision_flag and idles the device.
// (RULE13) Start condition sets start status; raises interrupt flag if start interrupt enabled.
// (RULE14) Firmware read of the data buffer clears buffer_full.
// (RULE15) Repeated start or stop leaves the device no longer addressed.

module i2c_slave_transmit (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial clock line, open drain
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_out_en,
  // Serial data line, open drain
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_out_en,
  // Interrupt
  output logic             irq
);

  i2c_slave_tx_pkg::tx_state_e state;

  logic       scl_meta;
  logic       scl_sync;
  logic       scl_prev;
  logic       sda_meta;
  logic       sda_sync;
  logic       sda_prev;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] tx_shift_reg;
  logic [7:0] port_data_buffer;
  logic       buffer_full;
  logic       dir_reg;
  logic       addressed_reg;
  logic       master_ack_status;
  logic       start_seen_reg;
  logic       stop_seen_reg;
  logic       clock_release;
  logic       slave_collision_detect_en;
  logic       start_ie_reg;
  logic       enable_reg;
  logic [6:0] own_addr_reg;
  logic [1:0] irq_request_reg;
  logic [1:0] irq_mask_reg;
  logic [31:0] rd_mux;
  logic       addr_hit;

  // Every check below runs on the system clock and sleeps through reset
  default clocking cb_pclk @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Bus lines cross from outside; the first stage is never read, only the second and third
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  wire scl_rise  = scl_sync & ~scl_prev;
  wire scl_fall  = ~scl_sync & scl_prev;
  wire start_det = sda_prev & ~sda_sync & scl_sync & scl_prev;
  wire stop_det  = ~sda_prev & sda_sync & scl_sync & scl_prev;

  // APB decode; one wait state keeps every answer from a flip-flop
  wire acc      = psel & penable & pready;
  wire wr_acc   = acc & pwrite & addr_hit;
  wire rd_acc   = acc & ~pwrite & addr_hit;
  wire wr_data  = wr_acc & (paddr == `DATA_BUF_OFS);
  wire rd_data  = rd_acc & (paddr == `DATA_BUF_OFS);
  wire wr_ctrl  = wr_acc & (paddr == `CONTROL_OFS);
  wire wr_own   = wr_acc & (paddr == `OWN_ADDR_OFS);
  wire wr_flag  = wr_acc & (paddr == `IRQ_FLAG_OFS);
  wire wr_mask  = wr_acc & (paddr == `IRQ_MASK_OFS);

  wire addr_match = enable_reg & (shift_in[7:1] == own_addr_reg) & shift_in[0];
  wire load_addr  = (state == i2c_slave_tx_pkg::ST_ADDR) & scl_fall
                    & (bit_cnt == `ADDR_BITS) & addr_match;
  wire ack9_fall  = (state == i2c_slave_tx_pkg::ST_ACK_WAIT) & scl_fall;
  wire hold_evt   = ((state == i2c_slave_tx_pkg::ST_ADDR_ACK) & scl_fall)
                    | (ack9_fall & ~master_ack_status);
  wire coll_det   = (state == i2c_slave_tx_pkg::ST_TX_BIT) & scl_rise & ~sda_out_en
                    & ~sda_sync & slave_collision_detect_en;
  wire byte_irq   = ((state == i2c_slave_tx_pkg::ST_ADDR_ACK) & scl_fall) | ack9_fall;
  wire start_irq  = start_det & start_ie_reg;

  always_comb begin
    addr_hit = 1'b1;
    rd_mux   = 32'h0;
    case (paddr)
      `DATA_BUF_OFS: rd_mux = {24'h0, port_data_buffer};
      `CONTROL_OFS:  rd_mux = {28'h0, enable_reg, start_ie_reg,
                               slave_collision_detect_en, clock_release};
      `OWN_ADDR_OFS: rd_mux = {25'h0, own_addr_reg};
      `STATUS_OFS:   rd_mux = {26'h0, addressed_reg, master_ack_status, stop_seen_reg,
                               start_seen_reg, buffer_full, dir_reg};
      `IRQ_FLAG_OFS: rd_mux = {30'h0, irq_request_reg};
      `IRQ_MASK_OFS: rd_mux = {30'h0, irq_mask_reg};
      default:       addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata  <= rd_mux;
        pslverr <= ~addr_hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_collision_detect_en <= 1'b0;
      start_ie_reg              <= 1'b0;
      enable_reg                <= 1'b0;
      own_addr_reg              <= `OWN_ADDR_RST;
      irq_mask_reg              <= `IRQ_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        slave_collision_detect_en <= pwdata[`CTRL_COLL_EN];
        start_ie_reg              <= pwdata[`CTRL_START_IE];
        enable_reg                <= pwdata[`CTRL_ENABLE];
      end
      if (wr_own) begin
        own_addr_reg <= pwdata[6:0];
      end
      if (wr_mask) begin
        irq_mask_reg <= pwdata[1:0];
      end
    end
  end

  // Firmware write wins, so a release written at the hold edge is not lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_release <= 1'b1;
    end else if (wr_ctrl) begin
      clock_release <= pwdata[`CTRL_RELEASE]; // RULE5
    end else if (hold_evt) begin
      clock_release <= 1'b0; // RULE2 RULE9
    end
  end

  // Data buffer and its full flag; a hardware set beats a read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_data_buffer <= 8'h0;
      buffer_full      <= 1'b0;
    end else begin
      if (load_addr) begin
        port_data_buffer <= shift_in; // RULE1
        buffer_full      <= 1'b1;
      end else if (wr_data) begin
        port_data_buffer <= pwdata[7:0];
      end else if (rd_data) begin
        buffer_full <= 1'b0; // RULE14
      end
    end
  end

  // Start and stop status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg  <= 1'b0;
    end else if (start_det) begin
      start_seen_reg <= 1'b1; // RULE13
      stop_seen_reg  <= 1'b0;
    end else if (stop_det) begin
      start_seen_reg <= 1'b0;
      stop_seen_reg  <= 1'b1;
    end
  end

  // Sticky events, write one to clear; a new event wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_request_reg <= 2'h0;
      irq             <= 1'b0;
    end else begin
      irq_request_reg <= (irq_request_reg & ~(wr_flag ? pwdata[1:0] : 2'h0))
                         | {coll_det, byte_irq | start_irq}; // RULE11 RULE12 RULE13
      irq             <= |(irq_request_reg & irq_mask_reg);
    end
  end

  // Bus sequencer; the pads only ever pull low, so the enables carry the level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_out           <= 1'b0;
      sda_out           <= 1'b0;
      state             <= i2c_slave_tx_pkg::ST_IDLE;
      bit_cnt           <= 4'h0;
      shift_in          <= 8'h0;
      tx_shift_reg      <= 8'h0;
      sda_out_en        <= 1'b0;
      scl_out_en        <= 1'b0;
      dir_reg           <= 1'b0;
      addressed_reg     <= 1'b0;
      master_ack_status <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_shift_reg <= pwdata[7:0]; // RULE4
      end
      if (stop_det) begin
        state         <= i2c_slave_tx_pkg::ST_IDLE; // RULE15
        sda_out_en    <= 1'b0;
        scl_out_en    <= 1'b0;
        addressed_reg <= 1'b0;
      end else if (start_det) begin
        state         <= i2c_slave_tx_pkg::ST_ADDR; // RULE15
        bit_cnt       <= 4'h0;
        sda_out_en    <= 1'b0;
        scl_out_en    <= 1'b0;
        dir_reg       <= 1'b0;
        addressed_reg <= 1'b0;
      end else begin
        case (state)
          i2c_slave_tx_pkg::ST_IDLE: begin
            sda_out_en <= 1'b0;
            scl_out_en <= 1'b0;
          end
          i2c_slave_tx_pkg::ST_ADDR: begin
            if (scl_rise) begin
              shift_in <= {shift_in[6:0], sda_sync};
              bit_cnt  <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == `ADDR_BITS) begin
              if (addr_match) begin
                state         <= i2c_slave_tx_pkg::ST_ADDR_ACK; // RULE1
                sda_out_en    <= 1'b1;
                dir_reg       <= 1'b1;
                addressed_reg <= 1'b1;
              end else begin
                state <= i2c_slave_tx_pkg::ST_IDLE;
              end
            end
          end
          i2c_slave_tx_pkg::ST_ADDR_ACK: begin
            if (scl_fall) begin
              state      <= i2c_slave_tx_pkg::ST_STRETCH;
              sda_out_en <= 1'b0;
              scl_out_en <= 1'b1; // RULE2
            end
          end
          i2c_slave_tx_pkg::ST_STRETCH: begin
            // First bit goes out in the same cycle that the clock line is let go
            if (clock_release) begin
              state      <= i2c_slave_tx_pkg::ST_TX_BIT;
              scl_out_en <= 1'b0; // RULE5
              sda_out_en <= ~tx_shift_reg[7];
              bit_cnt    <= 4'h0;
            end
          end
          i2c_slave_tx_pkg::ST_TX_BIT: begin
            if (coll_det) begin
              state         <= i2c_slave_tx_pkg::ST_IDLE; // RULE12
              addressed_reg <= 1'b0;
            end else if (scl_fall) begin
              if (bit_cnt == `LAST_DATA_BIT) begin
                state      <= i2c_slave_tx_pkg::ST_ACK_WAIT;
                sda_out_en <= 1'b0;
              end else begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0}; // RULE6
                sda_out_en   <= ~tx_shift_reg[6];
                bit_cnt      <= bit_cnt + 4'h1;
              end
            end
          end
          i2c_slave_tx_pkg::ST_ACK_WAIT: begin
            if (scl_rise) begin
              master_ack_status <= sda_sync; // RULE7
            end else if (scl_fall) begin
              if (master_ack_status) begin
                state         <= i2c_slave_tx_pkg::ST_IDLE; // RULE8 RULE10
                addressed_reg <= 1'b0;
              end else begin
                state      <= i2c_slave_tx_pkg::ST_STRETCH;
                scl_out_en <= 1'b1; // RULE9
              end
            end
          end
          default: begin
            state <= i2c_slave_tx_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  property p_addr_ack;
    $rose(state == i2c_slave_tx_pkg::ST_ADDR_ACK) |-> dir_reg && sda_out_en && buffer_full;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address ack state wrong"); // RULE1
  property p_hold_after_ack;
    (state == i2c_slave_tx_pkg::ST_ADDR_ACK && scl_fall && !wr_ctrl) |=>
      state == i2c_slave_tx_pkg::ST_STRETCH && scl_out_en && !clock_release;
  endproperty
  a_hold_after_ack: assert property (p_hold_after_ack) else $error("clock not held"); // RULE2
  property p_buf_loads_shift;
    (wr_data && state != i2c_slave_tx_pkg::ST_TX_BIT) |=> tx_shift_reg == $past(pwdata[7:0]);
  endproperty
  a_buf_loads_shift: assert property (p_buf_loads_shift) else $error("shift not loaded"); // RULE4
  property p_release;
    (state == i2c_slave_tx_pkg::ST_STRETCH && clock_release && !start_det && !stop_det) |=>
      !scl_out_en && sda_out_en == !$past(tx_shift_reg[7]);
  endproperty
  a_release: assert property (p_release) else $error("clock not released"); // RULE5
  property p_data_stable_high;
    (state == i2c_slave_tx_pkg::ST_TX_BIT && scl_sync) |=>
      state != i2c_slave_tx_pkg::ST_TX_BIT || $stable(sda_out_en);
  endproperty
  a_data_stable_high: assert property (p_data_stable_high) else $error("data moved"); // RULE6
  property p_ack_latch;
    (state == i2c_slave_tx_pkg::ST_ACK_WAIT && scl_rise && !stop_det && !start_det) |=>
      master_ack_status == $past(sda_sync);
  endproperty
  a_ack_latch: assert property (p_ack_latch) else $error("ack not latched"); // RULE7
  property p_nack_idle;
    (ack9_fall && master_ack_status) |=>
      state == i2c_slave_tx_pkg::ST_IDLE && !addressed_reg ##1 !scl_out_en;
  endproperty
  a_nack_idle: assert property (p_nack_idle) else $error("nack did not idle"); // RULE8 RULE10
  property p_ack_stretch;
    (ack9_fall && !master_ack_status) |=> state == i2c_slave_tx_pkg::ST_STRETCH && scl_out_en;
  endproperty
  a_ack_stretch: assert property (p_ack_stretch) else $error("no stretch after ack"); // RULE9
  property p_byte_irq;
    byte_irq |=> irq_request_reg[`IRQ_PORT];
  endproperty
  a_byte_irq: assert property (p_byte_irq) else $error("byte flag missing"); // RULE11
  property p_collision;
    (coll_det && !stop_det && !start_det) |=>
      irq_request_reg[`IRQ_COLL] && state == i2c_slave_tx_pkg::ST_IDLE;
  endproperty
  a_collision: assert property (p_collision) else $error("collision not handled"); // RULE12
  property p_start;
    (start_det && !stop_det) |=> start_seen_reg && state == i2c_slave_tx_pkg::ST_ADDR
      && (irq_request_reg[`IRQ_PORT] || !$past(start_ie_reg));
  endproperty
  a_start: assert property (p_start) else $error("start not recorded"); // RULE13
  property p_read_clears_full;
    (rd_data && !load_addr) |=> !buffer_full;
  endproperty
  a_read_clears_full: assert property (p_read_clears_full) else $error("full not cleared"); // RULE14
  property p_stop_unaddressed;
    (stop_det || start_det) |=> !addressed_reg ##1 !scl_out_en;
  endproperty
  a_stop_unaddressed: assert property (p_stop_unaddressed) else $error("still addressed"); // RULE15

endmodule // i2c_slave_transmit

// ===== hdl/i2c_slave_tx_defs.svh
`ifndef I2C_SLAVE_TX_DEFS_SVH
`define I2C_SLAVE_TX_DEFS_SVH

// Register byte offsets
`define DATA_BUF_OFS   8'h00
`define CONTROL_OFS    8'h04
`define OWN_ADDR_OFS   8'h08
`define STATUS_OFS     8'h0c
`define IRQ_FLAG_OFS   8'h10
`define IRQ_MASK_OFS   8'h14

// Control fields
`define CTRL_RELEASE   0
`define CTRL_COLL_EN   1
`define CTRL_START_IE  2
`define CTRL_ENABLE    3

// Status fields
`define STAT_DIR       0
`define STAT_FULL      1
`define STAT_START     2
`define STAT_STOP      3
`define STAT_ACK       4
`define STAT_ADDRESSED 5

// Interrupt flag fields
`define IRQ_PORT       0
`define IRQ_COLL       1

// Reset values and counts
`define OWN_ADDR_RST   7'h42
`define IRQ_MASK_RST   2'h0
`define ADDR_BITS      4'h8
`define LAST_DATA_BIT  4'h7

`endif

// ===== hdl/i2c_slave_tx_pkg.sv
package i2c_slave_tx_pkg;

  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,
    ST_ADDR     = 6'h02,
    ST_ADDR_ACK = 6'h04,
    ST_STRETCH  = 6'h08,
    ST_TX_BIT   = 6'h10,
    ST_ACK_WAIT = 6'h20
  } tx_state_e;

endpackage

// ===== verification/i2c_master_model.sv
`timescale 1ns/1ns
module i2c_master_model (
  // Clock
  input  wire logic pclk,
  // Line levels
  input  wire logic scl,
  input  wire logic sda,
  // Open-drain pulls, high pulls the line low
  output logic      scl_low,
  output logic      sda_low
);
  int half  = 3;
  int stall = 0;

  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // Waits out any stretch; a slave that never lets go trips the bench timeout
  task automatic rise();
    scl_low <= 1'b0;
    @(posedge pclk);
    while (scl !== 1'b1) begin
      @(posedge pclk);
    end
  endtask

  task automatic start();
    sda_low <= 1'b0;
    wt(half);
    rise();
    wt(half);
    sda_low <= 1'b1;
    wt(half);
    scl_low <= 1'b1;
    wt(1);
  endtask

  task automatic stop();
    sda_low <= 1'b1;
    wt(half);
    rise();
    wt(half);
    sda_low <= 1'b0;
    wt(half);
  endtask

  // Data moves one cycle after the fall, never with it
  task automatic bit_io(input logic b, input logic pull, output logic s);
    sda_low <= ~b | pull;
    wt(half + stall);
    rise();
    wt(half);
    s = sda;
    scl_low <= 1'b1;
    wt(1);
  endtask
endmodule // i2c_master_model

// ===== verification/test_i2c_slave_transmit.sv
`timescale 1ns/1ns
`include "i2c_slave_tx_defs.svh"
module test_i2c_slave_transmit;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr, b, v;
  logic [31:0] pwdata, prdata, rd;
  logic        scl_out, scl_out_en, sda_out, sda_out_en, m_scl_low, m_sda_low;
  logic        err, s, lst, nk;
  logic [6:0]  own;
  int          fails = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          nb;
  // Pull-ups hold both lines high unless someone pulls low
  wire         scl_w = ~m_scl_low & ~(scl_out_en & ~scl_out);
  wire         sda_w = ~m_sda_low & ~(sda_out_en & ~sda_out);

  i2c_slave_transmit i_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl_w), .scl_out(scl_out), .scl_out_en(scl_out_en),
    .sda_in(sda_w), .sda_out(sda_out), .sda_out_en(sda_out_en), .irq(irq));
  i2c_master_model i_mst (
    .pclk(pclk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  function automatic logic [7:0] exp_addr(input logic [6:0] a);
    return {a, 1'b1};
  endfunction

  task automatic addr(input logic [7:0] a, output logic ack);
    i_mst.start();
    for (int i = 7; i >= 0; i--)
      i_mst.bit_io(a[i], 1'b0, s);
    i_mst.bit_io(1'b1, 1'b0, ack);
    i_mst.wt(6);
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rd = $urandom(32'h3f09);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc("control", `CONTROL_OFS, 32'h1);
    rdc("own addr", `OWN_ADDR_OFS, {25'h0, `OWN_ADDR_RST});
    rdc("mask", `IRQ_MASK_OFS, 32'h0);
    wr(`STATUS_OFS, 32'h3f);
    rdc("status ro", `STATUS_OFS, 32'h0);
    rdc("unmapped", 8'h18, 32'h0);
    chk("slverr", err, 1'b1);
    addr(exp_addr(`OWN_ADDR_RST), s);
    chk("off ack", s, 1'b1);
    i_mst.stop();
    rdc("stop bit", `STATUS_OFS, 32'h8);
    $display("test registers done");
    wr(`CONTROL_OFS, 32'h9);
    wr(`IRQ_MASK_OFS, 32'h1);
    for (int k = 0; k < 6; k++) begin
      own = 7'($urandom);
      nb = 1 + $urandom % 3;
      nk = k[0];
      i_mst.stall = $urandom % 3;
      wr(`OWN_ADDR_OFS, {25'h0, own});
      addr(exp_addr(own), s);
      chk("ack", s, 1'b0);
      chk("stretch", scl_out_en, 1'b1);
      chk("irq", irq, 1'b1);
      rdc("release clr", `CONTROL_OFS, 32'h8);
      apb(1'b0, `STATUS_OFS, 32'h0);
      chk("dir", {rd[`STAT_FULL], rd[`STAT_DIR]}, 2'h3);
      rdc("buffer", `DATA_BUF_OFS, {24'h0, exp_addr(own)});
      apb(1'b0, `STATUS_OFS, 32'h0);
      chk("full clr", rd[`STAT_FULL], 1'b0);
      wr(`IRQ_FLAG_OFS, 32'h1);
      rdc("flag clr", `IRQ_FLAG_OFS, 32'h0);
      chk("irq clr", irq, 1'b0);
      for (int j = 0; j < nb; j++) begin
        b = 8'($urandom);
        if (k < 2)
          b = {8{k[0]}};
        lst = nk && j == nb - 1;
        wr(`DATA_BUF_OFS, {24'h0, b});
        wr(`CONTROL_OFS, 32'h9);
        repeat (2) @(posedge pclk);
        chk("released", scl_out_en, 1'b0);
        for (int i = 7; i >= 0; i--) begin
          i_mst.bit_io(1'b1, 1'b0, s);
          v[i] = s;
        end
        chk("byte", v, b);
        i_mst.bit_io(lst, 1'b0, s);
        i_mst.wt(6);
        apb(1'b0, `STATUS_OFS, 32'h0);
        chk("ack stat", rd[`STAT_ACK], lst);
        chk("hold", scl_out_en, !lst);
        rdc("flag", `IRQ_FLAG_OFS, 32'h1);
        wr(`IRQ_FLAG_OFS, 32'h1);
      end
      // Acked run ends with a repeated start, so the slave must give up SDA first
      if (!nk) begin
        wr(`DATA_BUF_OFS, 32'hff);
        wr(`CONTROL_OFS, 32'h9);
        i_mst.start();
      end
      apb(1'b0, `STATUS_OFS, 32'h0);
      chk("addressed", rd[`STAT_ADDRESSED], 1'b0);
      i_mst.stop();
      $display("test transfer %0d done", k);
    end
    for (int c = 0; c < 2; c++) begin
      addr(c ? exp_addr(own ^ 7'h1) : {own, 1'b0}, s);
      chk("refused", {s, scl_out_en}, 2'h2);
      i_mst.stop();
    end
    $display("test refusal done");
    wr(`IRQ_MASK_OFS, 32'h0);
    wr(`CONTROL_OFS, 32'hd);
    i_mst.start();
    rdc("start flag", `IRQ_FLAG_OFS, 32'h1);
    chk("masked", irq, 1'b0);
    apb(1'b0, `STATUS_OFS, 32'h0);
    chk("start bit", rd[`STAT_START], 1'b1);
    wr(`IRQ_MASK_OFS, 32'h3);
    rdc("mask set", `IRQ_MASK_OFS, 32'h3);
    chk("unmasked", irq, 1'b1);
    i_mst.stop();
    wr(`IRQ_FLAG_OFS, 32'h1);
    rdc("start clr", `IRQ_FLAG_OFS, 32'h0);
    $display("test start irq done");
    wr(`CONTROL_OFS, 32'hb);
    addr(exp_addr(own), s);
    wr(`IRQ_FLAG_OFS, 32'h3);
    wr(`DATA_BUF_OFS, 32'hff);
    wr(`CONTROL_OFS, 32'hb);
    i_mst.bit_io(1'b1, 1'b1, s);
    i_mst.wt(6);
    rdc("collision", `IRQ_FLAG_OFS, 32'h2);
    apb(1'b0, `STATUS_OFS, 32'h0);
    chk("coll idle", rd[`STAT_ADDRESSED], 1'b0);
    i_mst.bit_io(1'b1, 1'b0, s);
    chk("coll lines", {s, scl_out_en}, 2'h2);
    i_mst.stop();
    $display("test collision done");
    give_verdict();
  end
endmodule // test_i2c_slave_transmit
